// File: rtl/uart_defs.svh
// constants for the asynchronous serial port: oversampling, sample points,
// prescaler ratios. included by bare name; defines only.
`ifndef UART_DEFS_SVH
`define UART_DEFS_SVH

// =====================================================================
// oversampling
`define OVS_LAST      4'hf
`define SAMPLE_A      4'h7
`define SAMPLE_B      4'h8
`define SAMPLE_C      4'h9
`define START_SEEN    4'h1

// =====================================================================
// prescaler: clock/2 and clock/32 count sources
`define PRE_DIV2_LAST  5'h01
`define PRE_DIV32_LAST 5'h1f

// =====================================================================
// character framing
`define LAST_BIT_8    3'h7
`define LAST_BIT_7    3'h6

`endif

// File: rtl/uart_pkg.sv
// types shared by the serial port modules.
// assumes uart_defs.svh supplies the numeric constants.
package uart_pkg;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PAR,
    RX_STOP
  } rx_state_t;

  typedef enum logic [2:0] {
    TX_IDLE,
    TX_START,
    TX_DATA,
    TX_PAR,
    TX_STOP
  } tx_state_t;

endpackage

// File: rtl/baud_gen.sv
// baud divider: picks a count source and divides it by value plus one.
// assumes ext_clk_pin is asynchronous and well below the system clock.
`timescale 1ns/1ns
`default_nettype none
`include "uart_defs.svh"

module baud_gen #(
  parameter int DIV_W = 8
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             ext_clk_pin,
  input  wire logic             ext_clk_sel,
  input  wire logic             prescale_sel,
  input  wire logic [DIV_W-1:0] baud_div,
  output logic                  tick16
);

  // ===================================================================
  // external clock pin: three flops, level accepted when 2nd and 3rd agree
  logic       ext_s1_reg;
  logic       ext_s2_reg;
  logic       ext_s3_reg;
  logic       ext_lvl_reg;
  logic       ext_rise;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ext_s1_reg  <= 1'b0;
      ext_s2_reg  <= 1'b0;
      ext_s3_reg  <= 1'b0;
      ext_lvl_reg <= 1'b0;
    end else begin
      ext_s1_reg <= ext_clk_pin;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      if (ext_s2_reg == ext_s3_reg)
        ext_lvl_reg <= ext_s3_reg;
    end
  end

  assign ext_rise = (ext_s2_reg == ext_s3_reg) && ext_s3_reg && !ext_lvl_reg;

  // ===================================================================
  // internal prescaler, free running
  logic [4:0] pre_reg;
  logic       src_tick;

  always_ff @(posedge clock) begin
    if (sys_rst)
      pre_reg <= 5'h00;
    else
      pre_reg <= pre_reg + 5'h01;
  end

  // source select; the /2 path ticks on every odd count
  always_comb begin
    if (ext_clk_sel)
      src_tick = ext_rise;
    else if (prescale_sel)
      src_tick = (pre_reg == `PRE_DIV32_LAST);
    else
      src_tick = ((pre_reg & `PRE_DIV2_LAST) == `PRE_DIV2_LAST);
  end

  // ===================================================================
  // programmable divider; reprogram only while both directions are off
  logic [DIV_W-1:0] div_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      div_reg <= '0;
      tick16  <= 1'b0;
    end else begin
      tick16 <= 1'b0;
      if (src_tick) begin
        if (div_reg >= baud_div) begin
          div_reg <= '0;
          tick16  <= 1'b1;
        end else begin
          div_reg <= div_reg + {{(DIV_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule
`default_nettype wire

// File: rtl/async_serial_port_with_irq.sv
// full-duplex asynchronous serial port with receive/transmit interrupt requests.
// assumes the local processor drives the control bits as levels and the
// data strobes as one-cycle pulses on clock; rxd, cts and ext clk are async.
`timescale 1ns/1ns
`default_nettype none
`include "uart_defs.svh"

module async_serial_port_with_irq #(
  parameter int DIV_W = 8
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  // pins
  input  wire logic             rxd_pin,
  output logic                  txd_pin,
  input  wire logic             cts_pin_in,
  output logic                  cts_pin_out,
  output logic                  cts_pin_oe,
  input  wire logic             ext_clk_pin,
  // mode bits
  input  wire logic             parity_en,
  input  wire logic             parity_even,
  input  wire logic             char_len_7,
  input  wire logic             stop_len_2,
  input  wire logic             prescale_sel,
  input  wire logic             ext_clk_sel,
  input  wire logic             cts_dir_out,
  input  wire logic [DIV_W-1:0] baud_div,
  // control bits
  input  wire logic             tx_allow_bit,
  input  wire logic             tx_irq_en,
  input  wire logic             rx_enable,
  input  wire logic             rx_irq_en,
  input  wire logic             clear_to_send_select,
  input  wire logic             cts_out_data,
  input  wire logic             tx_side_init_bit,
  input  wire logic             error_clear_bit,
  // central interrupt enables and processor state
  input  wire logic             rx_irq_en_central,
  input  wire logic             tx_irq_en_central,
  input  wire logic             irq_disable,
  input  wire logic             rx_irq_taken,
  input  wire logic             tx_irq_taken,
  // data strobes
  input  wire logic [7:0]       tx_data,
  input  wire logic             tx_write,
  input  wire logic             rx_read,
  output logic [7:0]            rx_data,
  // status
  output logic                  tx_buffer_free_flag,
  output logic                  rx_buffer_full_flag,
  output logic                  tx_empty_flag,
  output logic                  parity_err_flag,
  output logic                  framing_err_flag,
  output logic                  overrun_err_flag,
  output logic                  cts_level,
  output logic                  rx_irq_req,
  output logic                  tx_irq_req,
  output logic                  rx_irq,
  output logic                  tx_irq
);

  // ===================================================================
  // baud tick
  logic tick;

  baud_gen #(.DIV_W(DIV_W)) u_baud (
    .clock        (clock),
    .sys_rst      (sys_rst),
    .ext_clk_pin  (ext_clk_pin),
    .ext_clk_sel  (ext_clk_sel),
    .prescale_sel (prescale_sel),
    .baud_div     (baud_div),
    .tick16       (tick)
  );

  // ===================================================================
  // pin synchronisers: three flops, level taken when 2nd and 3rd agree
  logic rx_s1_reg, rx_s2_reg, rx_s3_reg, rx_lvl_reg;
  logic ct_s1_reg, ct_s2_reg, ct_s3_reg, ct_lvl_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_s1_reg  <= 1'b1;
      rx_s2_reg  <= 1'b1;
      rx_s3_reg  <= 1'b1;
      rx_lvl_reg <= 1'b1;
      ct_s1_reg  <= 1'b1;
      ct_s2_reg  <= 1'b1;
      ct_s3_reg  <= 1'b1;
      ct_lvl_reg <= 1'b1;
    end else begin
      rx_s1_reg <= rxd_pin;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
      if (rx_s2_reg == rx_s3_reg)
        rx_lvl_reg <= rx_s3_reg;
      ct_s1_reg <= cts_pin_in;
      ct_s2_reg <= ct_s1_reg;
      ct_s3_reg <= ct_s2_reg;
      if (ct_s2_reg == ct_s3_reg)
        ct_lvl_reg <= ct_s3_reg;
    end
  end

  // general-purpose pin use only while the gate function is off
  assign cts_level   = ct_lvl_reg;
  assign cts_pin_out = cts_out_data;
  assign cts_pin_oe  = cts_dir_out && !clear_to_send_select;

  // ===================================================================
  // receiver
  uart_pkg::rx_state_t rx_st_reg;
  logic [3:0] rx_cnt_reg;
  logic [2:0] rx_bit_reg;
  logic [2:0] rx_smp_reg;
  logic [7:0] rx_shift_reg;
  logic       rx_par_reg;
  logic       rx_prev_reg;
  logic       rx_vote;
  logic       rx_done;
  logic       rx_par_bad;
  logic       rx_stop_bad;
  logic [2:0] last_bit;

  assign last_bit = char_len_7 ? `LAST_BIT_7 : `LAST_BIT_8;
  // two or more of three decide the bit
  assign rx_vote = (rx_smp_reg[0] & rx_smp_reg[1]) | (rx_smp_reg[0] & rx_smp_reg[2])
                 | (rx_smp_reg[1] & rx_smp_reg[2]);

  // sample window; the third sample is taken at cnt 9 and judged at cnt 10
  always_ff @(posedge clock) begin
    if (sys_rst)
      rx_smp_reg <= 3'h7;
    else if (tick && (rx_cnt_reg == `SAMPLE_A || rx_cnt_reg == `SAMPLE_B ||
                      rx_cnt_reg == `SAMPLE_C))
      rx_smp_reg <= {rx_smp_reg[1:0], rx_lvl_reg};
  end

  // bit-level sequencing; the stop bit is judged at its centre so a
  // following start edge is never missed
  always_ff @(posedge clock) begin
    if (sys_rst || !rx_enable) begin
      rx_st_reg    <= uart_pkg::RX_IDLE;
      rx_cnt_reg   <= 4'h0;
      rx_bit_reg   <= 3'h0;
      rx_prev_reg  <= 1'b1;
      rx_shift_reg <= 8'h00;
      rx_par_reg   <= 1'b0;
    end else if (tick) begin
      rx_cnt_reg <= rx_cnt_reg + 4'h1;
      case (rx_st_reg)
        uart_pkg::RX_IDLE: begin
          rx_prev_reg <= rx_lvl_reg;
          rx_cnt_reg  <= 4'h0;
          // second low tick after a high one
          if (!rx_lvl_reg && !rx_prev_reg) begin
            rx_st_reg   <= uart_pkg::RX_START;
            rx_cnt_reg  <= `START_SEEN + 4'h1;
            rx_prev_reg <= 1'b1;
          end
        end
        uart_pkg::RX_START: begin
          if (rx_cnt_reg == `SAMPLE_C + 4'h1 && rx_vote) begin
            rx_st_reg <= uart_pkg::RX_IDLE;
          end else if (rx_cnt_reg == `OVS_LAST) begin
            rx_st_reg    <= uart_pkg::RX_DATA;
            rx_bit_reg   <= 3'h0;
            rx_shift_reg <= 8'h00;
          end
        end
        uart_pkg::RX_DATA: begin
          if (rx_cnt_reg == `SAMPLE_C + 4'h1)
            rx_shift_reg[rx_bit_reg] <= rx_vote;
          if (rx_cnt_reg == `OVS_LAST) begin
            rx_bit_reg <= rx_bit_reg + 3'h1;
            if (rx_bit_reg == last_bit)
              rx_st_reg <= parity_en ? uart_pkg::RX_PAR : uart_pkg::RX_STOP;
          end
        end
        uart_pkg::RX_PAR: begin
          if (rx_cnt_reg == `SAMPLE_C + 4'h1)
            rx_par_reg <= rx_vote;
          if (rx_cnt_reg == `OVS_LAST)
            rx_st_reg <= uart_pkg::RX_STOP;
        end
        uart_pkg::RX_STOP: begin
          if (rx_cnt_reg == `SAMPLE_C + 4'h1)
            rx_st_reg <= uart_pkg::RX_IDLE;
        end
        default: rx_st_reg <= uart_pkg::RX_IDLE;
      endcase
    end
  end

  assign rx_done = tick && rx_enable && rx_st_reg == uart_pkg::RX_STOP &&
                   rx_cnt_reg == `SAMPLE_C + 4'h1;
  // with even sense the ones of data and parity total even
  assign rx_par_bad  = parity_en && ((^rx_shift_reg ^ rx_par_reg) != !parity_even);
  assign rx_stop_bad = !rx_vote;

  // receive buffer and flags; a hardware set beats a clear in the same cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_data             <= 8'h00;
      rx_buffer_full_flag <= 1'b0;
      parity_err_flag     <= 1'b0;
      framing_err_flag    <= 1'b0;
      overrun_err_flag    <= 1'b0;
      rx_irq_req          <= 1'b0;
    end else begin
      if (rx_read || !rx_enable)
        rx_buffer_full_flag <= 1'b0;
      if (error_clear_bit) begin
        parity_err_flag  <= 1'b0;
        framing_err_flag <= 1'b0;
        overrun_err_flag <= 1'b0;
      end
      if (rx_irq_taken)
        rx_irq_req <= 1'b0;
      if (rx_done) begin
        rx_data             <= rx_shift_reg;
        rx_buffer_full_flag <= 1'b1;
        rx_irq_req          <= 1'b1;
        if (rx_par_bad)
          parity_err_flag <= 1'b1;
        if (rx_stop_bad)
          framing_err_flag <= 1'b1;
        if (rx_buffer_full_flag && !rx_read)
          overrun_err_flag <= 1'b1;
      end
    end
  end

  assign rx_irq = rx_irq_req && rx_irq_en && rx_irq_en_central && !irq_disable;

  // ===================================================================
  // transmitter
  uart_pkg::tx_state_t tx_st_reg;
  logic [3:0] tx_cnt_reg;
  logic [2:0] tx_bit_reg;
  logic [7:0] tx_shift_reg;
  logic [7:0] tx_buf_reg;
  logic       tx_buf_full_reg;
  logic       tx_stop2_reg;
  logic       tx_en;
  logic       tx_load;
  logic       bit_end;

  // cts is active low; deselected means the pin does not matter
  assign tx_en   = tx_allow_bit && (!clear_to_send_select || !cts_level);
  assign bit_end = tick && tx_cnt_reg == `OVS_LAST;
  // start a character from idle on a tick, or straight after a stop bit
  assign tx_load = tx_en && tx_buf_full_reg && tick &&
                   (tx_st_reg == uart_pkg::TX_IDLE ||
                    (tx_st_reg == uart_pkg::TX_STOP && tx_cnt_reg == `OVS_LAST &&
                     (!stop_len_2 || tx_stop2_reg)));

  // frame sequencing; held in its initial state while init is low
  always_ff @(posedge clock) begin
    if (sys_rst || !tx_side_init_bit) begin
      tx_st_reg    <= uart_pkg::TX_IDLE;
      tx_cnt_reg   <= 4'h0;
      tx_bit_reg   <= 3'h0;
      tx_shift_reg <= 8'h00;
      tx_stop2_reg <= 1'b0;
      txd_pin      <= 1'b1;
    end else if (tx_load) begin
      tx_st_reg    <= uart_pkg::TX_START;
      tx_shift_reg <= tx_buf_reg;
      tx_cnt_reg   <= 4'h0;
      tx_stop2_reg <= 1'b0;
      txd_pin      <= 1'b0;
    end else if (tick && tx_st_reg != uart_pkg::TX_IDLE) begin
      tx_cnt_reg <= tx_cnt_reg + 4'h1;
      if (bit_end) begin
        case (tx_st_reg)
          uart_pkg::TX_START: begin
            tx_st_reg  <= uart_pkg::TX_DATA;
            tx_bit_reg <= 3'h0;
            txd_pin    <= tx_shift_reg[0];
          end
          uart_pkg::TX_DATA: begin
            tx_bit_reg <= tx_bit_reg + 3'h1;
            if (tx_bit_reg == last_bit) begin
              tx_st_reg <= parity_en ? uart_pkg::TX_PAR : uart_pkg::TX_STOP;
              txd_pin   <= parity_en ? ((^(tx_shift_reg & {!char_len_7, 7'h7f})) ^ !parity_even) : 1'b1;
            end else begin
              txd_pin <= tx_shift_reg[tx_bit_reg + 3'h1];
            end
          end
          uart_pkg::TX_PAR: begin
            tx_st_reg <= uart_pkg::TX_STOP;
            txd_pin   <= 1'b1;
          end
          uart_pkg::TX_STOP: begin
            if (stop_len_2 && !tx_stop2_reg)
              tx_stop2_reg <= 1'b1;
            else
              tx_st_reg <= uart_pkg::TX_IDLE;
            txd_pin <= 1'b1;
          end
          default: tx_st_reg <= uart_pkg::TX_IDLE;
        endcase
      end
    end
  end

  // buffer, ready and empty flags; the start bit going out frees the buffer
  always_ff @(posedge clock) begin
    if (sys_rst || !tx_side_init_bit) begin
      tx_buf_reg          <= 8'h00;
      tx_buf_full_reg     <= 1'b0;
      tx_buffer_free_flag <= 1'b1;
      tx_empty_flag       <= 1'b1;
      tx_irq_req          <= 1'b0;
    end else begin
      if (tx_irq_taken)
        tx_irq_req <= 1'b0;
      if (tx_load) begin
        tx_buf_full_reg     <= 1'b0;
        tx_buffer_free_flag <= 1'b1;
        tx_irq_req          <= 1'b1;
      end
      if (tick && tx_st_reg == uart_pkg::TX_IDLE && !tx_buf_full_reg)
        tx_empty_flag <= 1'b1;
      if (tx_write) begin
        tx_buf_reg          <= tx_data;
        tx_buf_full_reg     <= 1'b1;
        tx_buffer_free_flag <= 1'b0;
        tx_empty_flag       <= 1'b0;
      end
    end
  end

  assign tx_irq = tx_irq_req && tx_irq_en && tx_irq_en_central &&
                  !irq_disable && tx_en;

endmodule
`default_nettype wire

// File: test/serial_port_asserts.sv
// checker: relations between the serial port's flags, requests and pins.
// assumes it is bound onto the port's top level and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module serial_port_asserts (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic txd_pin,
  input wire logic cts_level,
  input wire logic tx_allow_bit,
  input wire logic tx_irq_en,
  input wire logic rx_enable,
  input wire logic rx_irq_en,
  input wire logic clear_to_send_select,
  input wire logic tx_side_init_bit,
  input wire logic error_clear_bit,
  input wire logic rx_irq_en_central,
  input wire logic tx_irq_en_central,
  input wire logic irq_disable,
  input wire logic tx_write,
  input wire logic rx_read,
  input wire logic tx_buffer_free_flag,
  input wire logic rx_buffer_full_flag,
  input wire logic tx_empty_flag,
  input wire logic parity_err_flag,
  input wire logic framing_err_flag,
  input wire logic overrun_err_flag,
  input wire logic rx_irq_req,
  input wire logic tx_irq_req,
  input wire logic rx_irq,
  input wire logic tx_irq
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (sys_rst);
  // =====================================================================
  // transmit side
  // init high now and before, so init release is excluded
  sequence start_out;
    $rose(tx_buffer_free_flag) && tx_side_init_bit && $past(tx_side_init_bit);
  endsequence
  sequence write_taken;
    tx_write && tx_side_init_bit;
  endsequence
  a_start_sets_req: assert property (start_out |-> tx_irq_req && !txd_pin)
    else $error("start bit left without transmit request");
  a_write_fills: assert property (write_taken |=> !tx_buffer_free_flag || !txd_pin)
    else $error("write left transmit buffer free");
  a_init_holds: assert property (!tx_side_init_bit |=> txd_pin && tx_buffer_free_flag && tx_empty_flag)
    else $error("transmit side not held initial");
  a_idle_high: assert property (tx_empty_flag |-> txd_pin)
    else $error("transmit line low while empty");
  a_tx_gate: assert property (tx_irq |-> tx_irq_req && tx_irq_en && tx_irq_en_central && !irq_disable
    && tx_allow_bit && (!clear_to_send_select || !cts_level))
    else $error("transmit interrupt outside its gating");
  // =====================================================================
  // receive side
  sequence char_in;
    $rose(rx_buffer_full_flag);
  endsequence
  a_char_req: assert property (char_in |-> rx_irq_req)
    else $error("received character without request");
  a_rx_gate: assert property (rx_irq == (rx_irq_req && rx_irq_en && rx_irq_en_central && !irq_disable))
    else $error("receive interrupt gating wrong");
  a_overrun_full: assert property ($rose(overrun_err_flag) |-> $past(rx_buffer_full_flag) && rx_buffer_full_flag)
    else $error("overrun without unread buffer");
  a_full_drop: assert property ($fell(rx_buffer_full_flag) |-> $past(rx_read) || !$past(rx_enable))
    else $error("full flag dropped without read");
  a_rx_off: assert property (!rx_enable |=> !rx_buffer_full_flag)
    else $error("full flag set while receiver off");
  a_err_drop: assert property ($fell(parity_err_flag) || $fell(framing_err_flag) || $fell(overrun_err_flag)
    |-> $past(error_clear_bit))
    else $error("error flag dropped without clear");
endmodule
bind async_serial_port_with_irq serial_port_asserts chk (.clock(clock), .sys_rst(sys_rst), .txd_pin(txd_pin),
  .cts_level(cts_level), .tx_allow_bit(tx_allow_bit), .tx_irq_en(tx_irq_en), .rx_enable(rx_enable),
  .rx_irq_en(rx_irq_en), .clear_to_send_select(clear_to_send_select), .tx_side_init_bit(tx_side_init_bit),
  .error_clear_bit(error_clear_bit), .rx_irq_en_central(rx_irq_en_central), .tx_irq_en_central(tx_irq_en_central),
  .irq_disable(irq_disable), .tx_write(tx_write), .rx_read(rx_read), .tx_buffer_free_flag(tx_buffer_free_flag),
  .rx_buffer_full_flag(rx_buffer_full_flag), .tx_empty_flag(tx_empty_flag), .parity_err_flag(parity_err_flag),
  .framing_err_flag(framing_err_flag), .overrun_err_flag(overrun_err_flag), .rx_irq_req(rx_irq_req),
  .tx_irq_req(tx_irq_req), .rx_irq(rx_irq), .tx_irq(tx_irq));
`default_nettype wire

// File: test/remote_station.sv
// remote serial station: sends frames into the port, decodes what it transmits.
// assumes bit_clks holds one bit time in system clocks and stays fixed per frame.
`timescale 1ns/1ns
`default_nettype none
module remote_station (
  input  wire logic        clock,
  input  wire logic [15:0] bit_clks,
  input  wire logic        parity_en,
  input  wire logic        parity_even,
  input  wire logic        txd,
  output var  logic        rxd
);
  logic [9:0] got_q[$];  // stop, parity, data of each decoded frame
  logic [9:0] frm;
  initial rxd = 1'b1;
  // =====================================================================
  // sending
  // one bit time, changed just after an edge
  task put_bit(input logic b);
    rxd <= b;
    repeat (bit_clks) @(posedge clock);
  endtask
  // trailing idle bit before any next start
  task send_frame(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    put_bit(1'b0);
    for (int i = 0; i < 8; i++) put_bit(d[i]);
    if (parity_en) put_bit((^d) ^ ~parity_even ^ bad_par);
    put_bit(~bad_stop);
    put_bit(1'b1);
  endtask
  // low pulse too short to be a start bit
  task glitch(input logic [15:0] n);
    rxd <= 1'b0;
    repeat (n) @(posedge clock);
    put_bit(1'b1);
  endtask
  // =====================================================================
  // receiving: samples each bit at its centre, lsb first
  always begin
    @(negedge txd);
    repeat (bit_clks / 2) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_clks) @(posedge clock);
      frm[i] = txd;
    end
    frm[8] = 1'b0;
    if (parity_en) begin
      repeat (bit_clks) @(posedge clock);
      frm[8] = txd;
    end
    repeat (bit_clks) @(posedge clock);
    frm[9] = txd;
    got_q.push_back(frm);
  end
endmodule
`default_nettype wire

// File: test/async_serial_port_with_irq_test.sv
// bench for the serial port: random bytes both ways, error and gating cases.
// assumes the remote station model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none
module async_serial_port_with_irq_test;
  logic        clock, sys_rst, rxd_pin, txd_pin, cts_pin_in, cts_pin_out, cts_pin_oe, ext_clk_pin;
  logic        parity_en, parity_even, char_len_7, stop_len_2, prescale_sel, ext_clk_sel, cts_dir_out;
  logic        tx_allow_bit, tx_irq_en, rx_enable, rx_irq_en, clear_to_send_select, cts_out_data;
  logic        tx_side_init_bit, rx_irq_en_central, tx_irq_en_central, irq_disable, cts_level;
  logic        tx_buffer_free_flag, rx_buffer_full_flag, tx_empty_flag, parity_err_flag;
  logic        framing_err_flag, overrun_err_flag, rx_irq_req, tx_irq_req, rx_irq, tx_irq;
  logic        tx_write, rx_read, rx_irq_taken, tx_irq_taken, error_clear_bit;
  logic [7:0]  baud_div, tx_data, rx_data, d;
  logic [4:0]  strb;  // one-cycle strobes, one bit each
  logic [15:0] bit_clks;
  logic [9:0]  exp_q[$];
  int          n_errors, checks_done;
  assign {error_clear_bit, tx_irq_taken, rx_irq_taken, rx_read, tx_write} = strb;
  async_serial_port_with_irq uut (.*);
  remote_station st (.clock(clock), .bit_clks(bit_clks), .parity_en(parity_en), .parity_even(parity_even),
    .txd(txd_pin), .rxd(rxd_pin));
  // =====================================================================
  // clock, verdict, compares
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task close_out();
    if (n_errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk_bit(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task chk_vec(input logic [9:0] got, input logic [9:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // =====================================================================
  // drivers
  task pulse(input int b);
    strb[b] <= 1'b1;
    @(posedge clock);
    strb <= '0;
    @(posedge clock);
  endtask
  // expected frame: stop, parity, data
  function logic [9:0] frame_of(input logic [7:0] v);
    return {1'b1, (^v) ^ ~parity_even, v};
  endfunction
  task send_byte(input logic [7:0] v);
    tx_data <= v;
    exp_q.push_back(frame_of(v));
    pulse(0);
  endtask
  // bounded wait on free (0) or empty (1)
  task wait_for(input int which, input int lim);
    for (int i = 0; i < lim; i++) begin
      if (((which == 0) ? tx_buffer_free_flag : tx_empty_flag) === 1'b1) return;
      @(posedge clock);
    end
    chk_bit(1'b0, 1'b1, "flag wait ran out");
  endtask
  task check_tx();
    chk_vec(10'(st.got_q.size()), 10'(exp_q.size()), "frame count");
    while (exp_q.size() > 0 && st.got_q.size() > 0) chk_vec(st.got_q.pop_front(), exp_q.pop_front(), "tx frame");
    exp_q.delete();
    st.got_q.delete();
  endtask
  // =====================================================================
  // watchdog
  initial begin
    repeat (60000) @(posedge clock);
    n_errors++;
    close_out();
  end
  // =====================================================================
  // main sequence
  initial begin
    void'($urandom(32'h914c));
    {ext_clk_pin, ext_clk_sel, char_len_7, prescale_sel} = '0;  // tied: clock/2 source only
    {clear_to_send_select, irq_disable, cts_pin_in, strb, tx_data} = '0;
    {parity_en, tx_allow_bit, tx_irq_en, rx_enable, rx_irq_en, tx_side_init_bit} = '1;
    {rx_irq_en_central, tx_irq_en_central, parity_even} = '1;
    stop_len_2 = 1'($urandom);
    {cts_dir_out, cts_out_data} = 2'($urandom);
    baud_div = 8'($urandom_range(2, 0));
    bit_clks = 16'(32 * (baud_div + 1));  // 16 ticks, each 2(n+1) clocks
    n_errors = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk_vec({8'h00, cts_pin_out, cts_pin_oe}, {8'h00, cts_out_data, cts_dir_out}, "cts pins");
    // random characters in both parity senses, with interrupt gating varied
    for (int k = 0; k < 6; k++) begin
      d = 8'($urandom);
      parity_even <= k[0];
      irq_disable <= k[1];
      @(posedge clock);
      st.send_frame(d, 1'b0, 1'b0);
      chk_vec({2'b00, rx_data}, {2'b00, d}, "rx data");
      chk_bit(rx_buffer_full_flag, 1'b1, "rx full");
      chk_bit(rx_irq_req, 1'b1, "rx request");
      chk_bit(parity_err_flag | framing_err_flag | overrun_err_flag, 1'b0, "errors");
      chk_bit(rx_irq, ~k[1], "rx irq");
      pulse(2);
      chk_bit(rx_irq_req, 1'b0, "rx request taken");
      pulse(1);
      chk_bit(rx_buffer_full_flag, 1'b0, "read clears full");
    end
    irq_disable <= 1'b0;
    // bad parity, then low stop on an unread buffer
    st.send_frame(8'ha5, 1'b1, 1'b0);
    chk_bit(parity_err_flag, 1'b1, "parity error");
    st.send_frame(8'h3c, 1'b0, 1'b1);
    chk_bit(framing_err_flag, 1'b1, "framing error");
    chk_bit(overrun_err_flag, 1'b1, "overrun");
    chk_vec({2'b00, rx_data}, 10'h03c, "newer char kept");
    pulse(4);
    chk_bit(parity_err_flag | framing_err_flag | overrun_err_flag, 1'b0, "error clear");
    pulse(1);
    // false start then a real character
    st.glitch(16'(8 * (baud_div + 1)));
    chk_bit(rx_buffer_full_flag, 1'b0, "false start");
    d = 8'($urandom);
    st.send_frame(d, 1'b0, 1'b0);
    chk_vec({2'b00, rx_data}, {2'b00, d}, "after false start");
    pulse(1);
    rx_enable <= 1'b0;
    @(posedge clock);
    st.send_frame(8'h81, 1'b0, 1'b0);
    chk_bit(rx_buffer_full_flag, 1'b0, "receiver off");
    rx_enable <= 1'b1;
    // back-to-back transmit with request taken between
    send_byte(8'($urandom));
    wait_for(0, 64);
    chk_bit(tx_irq_req, 1'b1, "tx request");
    chk_bit(tx_irq, 1'b1, "tx irq");
    pulse(3);
    chk_bit(tx_irq_req, 1'b0, "tx request taken");
    send_byte(8'($urandom));
    wait_for(1, 40 * bit_clks);
    check_tx();
    // writes ignored while the transmit side is held initial
    tx_side_init_bit <= 1'b0;
    @(posedge clock);
    tx_data <= 8'($urandom);
    pulse(0);
    repeat (13 * bit_clks) @(posedge clock);
    chk_vec(10'(st.got_q.size()), 10'd0, "init blocks");
    chk_bit(tx_empty_flag, 1'b1, "init empty");
    tx_side_init_bit <= 1'b1;
    // clear-to-send gating selected, then deselected
    clear_to_send_select <= 1'b1;
    cts_pin_in <= 1'b1;
    repeat (4) @(posedge clock);
    send_byte(8'($urandom));
    repeat (13 * bit_clks) @(posedge clock);
    chk_vec(10'(st.got_q.size()), 10'd0, "cts holds");
    chk_vec({8'h00, cts_level, cts_pin_oe}, 10'h002, "cts gate pins");
    cts_pin_in <= 1'b0;
    wait_for(1, 40 * bit_clks);
    check_tx();
    clear_to_send_select <= 1'b0;
    cts_pin_in <= 1'b1;
    @(posedge clock);
    send_byte(8'($urandom));
    wait_for(1, 40 * bit_clks);
    check_tx();
    close_out();
  end
endmodule
`default_nettype wire
